/* File: core/eecs_sequencer.sv */
`timescale 1ns/100ps
module eecs_sequencer
#(
    parameter int PROG_CYC = eecs_pkg::PROG_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        ce,
    input  wire logic        launch,
    input  wire logic [2:0]  param_index,
    input  wire logic [15:0] param_word0,
    input  wire logic [15:0] param_word1,
    input  wire logic [15:0] param_word2,
    input  wire logic [15:0] param_word3,
    input  wire logic [15:0] param_word4,
    input  wire logic [15:0] param_word5,
    input  wire logic        mode_allowed,
    input  wire logic [9:0]  protect_from,
    input  wire logic        read_err,
    input  wire logic        read_uncorr,
    input  wire logic        status_clear,
    output logic             command_complete_flag,
    output logic             access_error_flag,
    output logic             protection_violation_flag,
    output logic             verify_status_hi,
    output logic             verify_status_lo
);
    import eecs_pkg::*;

    // ------------------------------------------------------------
    // decode and launch checks
    // ------------------------------------------------------------
    eecs_state_type state_reg;
    logic [7:0]    cmd_reg;
    logic [9:0]    addr_reg;
    logic [9:0]    last_reg;
    logic [15:0]   data_reg [0:3];
    logic [7:0]    cnt_reg;
    logic          wr_en;
    logic [15:0]   wdata;
    logic [15:0]   rdata;
    logic          fail_reg;

    wire [7:0]  cmd   = param_word0[15:8];                      // RULE_01
    wire [23:0] gaddr = {param_word0[7:0], param_word1};
    wire [23:0] off   = gaddr - EE_BASE;
    wire [9:0]  woff  = off[10:1];
    wire        in_blk = (gaddr >= EE_BASE) && (off[23:1] < 23'(EE_WORDS)); // RULE_07
    wire [16:0] ev_end = 17'(woff) + 17'(param_word2);
    wire [16:0] pg_end = 17'(woff) + 17'(param_index - IDX_TWO) + 17'h1;

    // true when command parameters fail the access checks
    function automatic logic acc_bad(input logic [7:0] c, input logic [2:0] ix);
        logic bad;
        bad = !mode_allowed || gaddr[0] || !in_blk;            // RULE_06 RULE_07 RULE_08
        case (c)
            CMD_ERASE_VERIFY: bad = bad || ix != IDX_TWO       // RULE_04
                                    || ev_end > 17'(EE_WORDS); // RULE_05
            CMD_PROGRAM:      bad = bad || ix < IDX_TWO || ix > IDX_FIVE // RULE_12
                                    || pg_end > 17'(EE_WORDS); // RULE_13
            CMD_ERASE_SECTOR: bad = bad || ix != IDX_ONE;      // RULE_18
            default:          bad = 1'b1;
        endcase
        return bad;
    endfunction

    wire [9:0] sec_base = woff & ~10'(SECTOR_WORDS - 1);       // RULE_17
    // eleven bits so a sector at the top of the block cannot wrap under the limit
    wire       prot_hit = (cmd == CMD_PROGRAM && pg_end > 17'(protect_from))
                       || (cmd == CMD_ERASE_SECTOR
                           && 11'(sec_base) + 11'(SECTOR_WORDS) > 11'(protect_from)); // RULE_14

    eecs_array #(.AW(EE_AW), .DW(16)) u_array (
        .clk_sys (clk_sys),
        .ce      (ce),
        .wr_en   (wr_en),
        .addr    (addr_reg),
        .wdata   (wdata),
        .rdata   (rdata)
    );

    assign wr_en = ce && state_reg == ST_WRITE;
    assign wdata = (cmd_reg == CMD_PROGRAM) ? data_reg[2'(addr_reg - last_reg + 10'(cnt_reg))] : ERASED_WORD;

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    // launch is honoured only while idle; a write to a busy engine is dropped
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
            cmd_reg   <= 8'h00;
            addr_reg  <= 10'h000;
            last_reg  <= 10'h000;
            cnt_reg   <= 8'h00;
            fail_reg  <= 1'b0;
            for (int i = 0; i < 4; i++) data_reg[i] <= 16'h0000;
        end else if (ce) begin
            case (state_reg)
                ST_IDLE: begin
                    if (launch) begin
                        cmd_reg   <= cmd;
                        data_reg[0] <= param_word2;
                        data_reg[1] <= param_word3;
                        data_reg[2] <= param_word4;
                        data_reg[3] <= param_word5;
                        fail_reg  <= 1'b0;
                        if (acc_bad(cmd, param_index) || prot_hit) begin
                            state_reg <= ST_DONE;                   // RULE_21 RULE_14
                        end else begin
                            case (cmd)
                                CMD_ERASE_VERIFY: begin
                                    addr_reg <= woff;
                                    last_reg <= woff + param_word2[9:0] - 10'h1;
                                    state_reg <= (param_word2 == 16'h0000) ? ST_DONE : ST_READ; // RULE_02
                                end
                                CMD_PROGRAM: begin
                                    addr_reg <= woff;
                                    last_reg <= woff + 10'(param_index - IDX_TWO); // RULE_11 RULE_10
                                    cnt_reg  <= 8'(param_index - IDX_TWO);
                                    state_reg <= ST_CHECK;
                                end
                                default: begin
                                    addr_reg <= sec_base;
                                    last_reg <= sec_base + 10'(SECTOR_WORDS - 1);
                                    cnt_reg  <= 8'(SECTOR_WORDS - 1);
                                    state_reg <= ST_CHECK;
                                end
                            endcase
                        end
                    end
                end
                ST_CHECK: begin
                    state_reg <= ST_WRITE;
                end
                ST_WRITE: begin
                    if (addr_reg == last_reg) begin
                        addr_reg  <= last_reg - 10'(cnt_reg);     // rewind for verify
                        cnt_reg   <= 8'(PROG_CYC);
                        state_reg <= ST_WAIT;
                    end else begin
                        addr_reg <= addr_reg + 10'h1;
                    end
                end
                ST_WAIT: begin
                    // array settle time before verify reads
                    if (cnt_reg <= 8'h1) begin
                        state_reg <= ST_READ;                      // RULE_15 RULE_19
                    end
                    cnt_reg <= cnt_reg - 8'h1;
                end
                ST_READ: begin
                    state_reg <= ST_CMP;
                end
                ST_CMP: begin
                    if (addr_reg == last_reg) begin
                        state_reg <= ST_DONE;
                    end else begin
                        addr_reg  <= addr_reg + 10'h1;
                        state_reg <= ST_READ;
                    end
                end
                ST_DONE: begin
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // flags; one registered cycle after done the completion flag rises
    // ------------------------------------------------------------
    logic [9:0] data_idx_span;
    wire [15:0] expect_word = (cmd_reg == CMD_PROGRAM) ?
                              data_reg[2'(addr_reg - (last_reg - 10'(data_idx_span)))] : ERASED_WORD;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            data_idx_span <= 10'h000;
        end else if (ce && state_reg == ST_IDLE && launch) begin
            data_idx_span <= 10'(param_index - IDX_TWO);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            command_complete_flag     <= 1'b1;
            access_error_flag         <= 1'b0;
            protection_violation_flag <= 1'b0;
            verify_status_hi          <= 1'b0;
            verify_status_lo          <= 1'b0;
        end else if (ce) begin
            if (state_reg == ST_IDLE && launch) begin
                command_complete_flag <= 1'b0;
                verify_status_hi      <= 1'b0;
                verify_status_lo      <= 1'b0;
                if (acc_bad(cmd, param_index)) begin
                    access_error_flag <= 1'b1;                    // RULE_04 RULE_12 RULE_18
                end else if (prot_hit) begin
                    protection_violation_flag <= 1'b1;            // RULE_14
                end
            end else begin
                if (status_clear) begin
                    access_error_flag         <= 1'b0;
                    protection_violation_flag <= 1'b0;
                end
                if (state_reg == ST_CMP) begin
                    if (rdata != expect_word) begin
                        verify_status_hi <= 1'b1;                 // RULE_03 RULE_16
                        verify_status_lo <= 1'b1;
                    end
                    if (read_err) verify_status_hi <= 1'b1;       // RULE_09 RULE_16
                    if (read_uncorr) verify_status_lo <= 1'b1;    // RULE_09 RULE_16
                end
                if (state_reg == ST_DONE) begin
                    command_complete_flag <= 1'b1;                // RULE_02 RULE_21
                end
            end
        end
    end
endmodule

/* File: core/eecs_pkg.sv */
// Overview of operation
// RULE_01 - erase-verify code 0x10: word0 code+addr hi, word1 addr lo, word2 count
// RULE_02 - launch by clearing completion; check range erased, then set completion
// RULE_03 - any unerased word in range sets both verify status bits
// RULE_04 - erase-verify needs param index 010, else access error, no run
// RULE_05 - erase-verify range running past block end gives access error
// RULE_06 - odd word address (bit 0 set) gives access error, all commands
// RULE_07 - address outside the eeprom block gives access error, all commands
// RULE_08 - command not allowed in current mode gives access error
// RULE_09 - erase-verify read error sets hi bit, uncorrectable sets lo bit
// RULE_10 - program code 0x11: word1 addr lo, words 2..5 data, one to four words
// RULE_11 - word count to program comes from param index at launch
// RULE_12 - program param index below 010 or above 101 gives access error
// RULE_13 - program group running past block end gives access error
// RULE_14 - protected target for program or sector erase: violation flag, no change
// RULE_15 - after programming verify written words, then set completion
// RULE_16 - verify error sets hi bit, uncorrectable verify error sets lo bit
// RULE_17 - sector erase code 0x12: any address in sector, whole sector erased
// RULE_18 - sector erase needs param index 001, else access error, no erase
// RULE_19 - after sector erase verify sector erased, then set completion
// RULE_20 - software programs only erased words, never reprograms bits
// RULE_21 - launch error or violation skips array work, completion set at once
package eecs_pkg;
    // ------------------------------------------------------------
    // command codes and parameter indices
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_ERASE_VERIFY = 8'h10;
    localparam logic [7:0] CMD_PROGRAM      = 8'h11;
    localparam logic [7:0] CMD_ERASE_SECTOR = 8'h12;
    localparam logic [2:0] IDX_ONE          = 3'h1;
    localparam logic [2:0] IDX_TWO          = 3'h2;
    localparam logic [2:0] IDX_FIVE         = 3'h5;
    // ------------------------------------------------------------
    // eeprom block map (word array)
    // ------------------------------------------------------------
    localparam logic [23:0] EE_BASE         = 24'h100000;
    localparam int          EE_WORDS        = 1024;
    localparam int          EE_AW           = 10;
    localparam int          SECTOR_WORDS    = 2;
    localparam logic [15:0] ERASED_WORD     = 16'hffff;
    // ------------------------------------------------------------
    // array timing
    // ------------------------------------------------------------
    localparam int          PROG_TIME_NS    = 50;
    localparam int          CLK_PERIOD_NS   = 5;
    localparam int          PROG_CYCLES     = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0]  RESET_IDX       = 3'h0;
    typedef enum logic [6:0] {
        ST_IDLE   = 7'b0000001,
        ST_CHECK  = 7'b0000010,
        ST_WRITE  = 7'b0000100,
        ST_WAIT   = 7'b0001000,
        ST_READ   = 7'b0010000,
        ST_CMP    = 7'b0100000,
        ST_DONE   = 7'b1000000
    } eecs_state_type;
endpackage

/* File: core/eecs_array.sv */
`timescale 1ns/100ps
// word memory standing in for the eeprom cells; registered read
module eecs_array #(
    parameter int AW = 10,
    parameter int DW = 16
) (
    input  wire logic          clk_sys,
    input  wire logic          ce,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // write-through has no effect on read data this cycle
    always_ff @(posedge clk_sys) begin
        if (ce) begin
            if (wr_en) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end
endmodule

/* File: tb/eecs_sequencer_chk.sv */
`timescale 1ns/100ps
// watches the sequencer ports; all launch checks are seen one edge after the taking edge
module eecs_sequencer_chk #(
    parameter int PROG_CYC = eecs_pkg::PROG_CYCLES
) (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        ce,
    input wire logic        launch,
    input wire logic [2:0]  param_index,
    input wire logic [15:0] param_word0,
    input wire logic [15:0] param_word1,
    input wire logic        mode_allowed,
    input wire logic        command_complete_flag,
    input wire logic        access_error_flag,
    input wire logic        protection_violation_flag,
    input wire logic        verify_status_hi,
    input wire logic        verify_status_lo
);
    import eecs_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // a launch is only taken while idle, which the high completion flag stands for
    wire logic       go = ce && launch && command_complete_flag;
    wire logic [7:0] code = param_word0[15:8];
    wire logic       ee_cmd = code == CMD_ERASE_VERIFY || code == CMD_PROGRAM || code == CMD_ERASE_SECTOR;
    // cycles spent busy; the longest job is a full-block erase verify at two cycles a word
    int              low_cnt;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            low_cnt <= 0;
        end else if (ce) begin
            low_cnt <= command_complete_flag ? 0 : low_cnt + 1;
        end
    end
    a_busy_bound: assert property (low_cnt <= 2 * EE_WORDS + PROG_CYC + 8)
        else $error("command stayed busy too long");
    a_below_blk: assert property (go && ee_cmd && {param_word0[7:0], param_word1} < EE_BASE
        |=> access_error_flag)
        else $error("address below the block not flagged");
    a_launch_drop: assert property (go |=> !command_complete_flag)
        else $error("completion stayed high after a launch");
    a_err_quick: assert property ($rose(access_error_flag) |-> ##2 command_complete_flag && !verify_status_hi)
        else $error("rejected launch did not finish at once");
    a_viol_quick: assert property ($rose(protection_violation_flag) |-> ##2 command_complete_flag)
        else $error("protected launch did not finish at once");
    a_mode_err: assert property (go && ee_cmd && !mode_allowed |=> access_error_flag)
        else $error("disallowed mode not flagged");
    a_ev_index: assert property (go && code == CMD_ERASE_VERIFY && param_index != IDX_TWO
        |=> access_error_flag)
        else $error("bad index for erase verify not flagged");
    a_prog_index: assert property (go && code == CMD_PROGRAM && (param_index < IDX_TWO || param_index > IDX_FIVE)
        |=> access_error_flag)
        else $error("bad index for program not flagged");
    a_sect_index: assert property (go && code == CMD_ERASE_SECTOR && param_index != IDX_ONE
        |=> access_error_flag)
        else $error("bad index for sector erase not flagged");
    a_odd_addr: assert property (go && ee_cmd && param_word1[0] |=> access_error_flag)
        else $error("odd word address not flagged");
    a_verify_hold: assert property (command_complete_flag && $past(command_complete_flag)
        |-> $stable({verify_status_hi, verify_status_lo}))
        else $error("verify status moved while idle");
endmodule
bind eecs_sequencer eecs_sequencer_chk #(.PROG_CYC(PROG_CYC)) u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce),
    .launch(launch), .param_index(param_index), .param_word0(param_word0), .param_word1(param_word1),
    .mode_allowed(mode_allowed), .command_complete_flag(command_complete_flag), .access_error_flag(access_error_flag),
    .protection_violation_flag(protection_violation_flag), .verify_status_hi(verify_status_hi),
    .verify_status_lo(verify_status_lo));

/* File: tb/eecs_err_src.sv */
`timescale 1ns/100ps
// stands in for the array sense path: reports read faults only when the bench asks for them
module eecs_err_src (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic inject_err,
    input  wire logic inject_uncorr,
    output logic      read_err,
    output logic      read_uncorr
);
    // fault levels follow the request one cycle late, like a registered sense result
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            read_err    <= 1'b0;
            read_uncorr <= 1'b0;
        end else begin
            read_err    <= inject_err;
            read_uncorr <= inject_uncorr;
        end
    end
endmodule

/* File: tb/eecs_sequencer_tb.sv */
`timescale 1ns/100ps
module eecs_sequencer_tb;
    import eecs_pkg::*;
    logic        clk_sys = 1'b0, reset_n = 1'b0, launch = 1'b0, mode_allowed = 1'b1, status_clear = 1'b0;
    logic        inj_err = 1'b0, inj_unc = 1'b0;
    logic [2:0]  param_index = 3'h0;
    logic [9:0]  protect_from = 10'h200;
    logic [15:0] pw [6] = '{default: 16'h0000};
    wire logic   read_err, read_uncorr, ccf, aef, pvf, vhi, vlo;
    int          fails = 0, checks_done = 0;
    logic [31:0] lfsr = 32'hefb15019;
    int          mem [int];
    always #2.5 clk_sys = ~clk_sys;
    eecs_sequencer u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .ce(1'b1), .launch(launch), .param_index(param_index),
        .param_word0(pw[0]), .param_word1(pw[1]), .param_word2(pw[2]), .param_word3(pw[3]), .param_word4(pw[4]),
        .param_word5(pw[5]), .mode_allowed(mode_allowed), .protect_from(protect_from), .read_err(read_err),
        .read_uncorr(read_uncorr), .status_clear(status_clear), .command_complete_flag(ccf), .access_error_flag(aef),
        .protection_violation_flag(pvf), .verify_status_hi(vhi), .verify_status_lo(vlo));
    eecs_err_src u_err (.clk_sys(clk_sys), .reset_n(reset_n), .inject_err(inj_err), .inject_uncorr(inj_unc),
        .read_err(read_err), .read_uncorr(read_uncorr));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] next_rand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[15:0];
    endfunction
    task automatic check_flag(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // one command: model prediction, status clear, launch, bounded wait, flag compares
    task automatic run_cmd(input logic [7:0] code, input logic [2:0] idx, input logic [23:0] addr,
                           input logic [15:0] cnt, input logic re, input logic ru);
        int  off, n, lo_w, i;
        bit  ae, pv, ue, done;
        off  = int'(addr) - int'(EE_BASE);
        n    = (code == CMD_ERASE_VERIFY) ? int'(cnt) : (code == CMD_PROGRAM) ? int'(idx) - 1 : SECTOR_WORDS;
        lo_w = (code == CMD_ERASE_SECTOR) ? (off / 2) / SECTOR_WORDS * SECTOR_WORDS : off / 2;
        ae   = !mode_allowed || addr[0] || off < 0 || off >= 2 * EE_WORDS || lo_w + n > EE_WORDS
            || (code == CMD_ERASE_VERIFY && idx != IDX_TWO) || (code == CMD_ERASE_SECTOR && idx != IDX_ONE)
            || (code == CMD_PROGRAM && (idx < IDX_TWO || idx > IDX_FIVE));
        pv   = !ae && code != CMD_ERASE_VERIFY && lo_w + n - 1 >= int'(protect_from);
        ue   = 1'b0;
        for (i = 0; i < n && code == CMD_ERASE_VERIFY; i++)
            if (!mem.exists(lo_w + i) || mem[lo_w + i] != 'hffff) ue = 1;
        pw[0] = {code, addr[23:16]};
        pw[1] = addr[15:0];
        pw[2] = cnt;
        for (i = 0; i < 4 && code == CMD_PROGRAM; i++) pw[2 + i] = next_rand();
        for (i = 0; i < n && !ae && !pv && code != CMD_ERASE_VERIFY; i++)
            mem[lo_w + i] = (code == CMD_PROGRAM) ? int'(pw[2 + i]) : 'hffff;
        param_index = idx;
        inj_err = re;
        inj_unc = ru;
        status_clear = 1'b1;
        @(posedge clk_sys) #1 status_clear = 1'b0;
        launch = 1'b1;
        @(posedge clk_sys) #1 launch = 1'b0;
        check_flag(ccf, 1'b0, "completion after launch");
        done = 0;
        for (i = 0; i < 4000 && !done; i++) if (ccf === 1'b1) done = 1; else @(posedge clk_sys) #1;
        if (!done) begin
            fails++;
            $display("[ERR] %0t command never completed", $time);
            print_verdict();
        end
        check_flag(aef, ae, "access error");
        check_flag(pvf, pv, "protection violation");
        check_flag(vhi, !ae && !pv && n > 0 && (ue || re), "verify hi");
        check_flag(vlo, !ae && !pv && n > 0 && (ue || ru), "verify lo");
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        run_cmd(CMD_ERASE_SECTOR, 3'h1, 24'h100010, 16'h0000, 0, 0);
        run_cmd(CMD_ERASE_SECTOR, 3'h1, 24'h100016, 16'h0000, 0, 0);
        run_cmd(CMD_ERASE_VERIFY, 3'h2, 24'h100010, 16'h0004, 0, 0);
        run_cmd(CMD_PROGRAM, 3'h5, 24'h100010, 16'h0000, 0, 0);
        run_cmd(CMD_ERASE_VERIFY, 3'h2, 24'h100010, 16'h0004, 0, 0);
        run_cmd(CMD_ERASE_SECTOR, 3'h1, 24'h100012, 16'h0000, 0, 0);
        run_cmd(CMD_ERASE_VERIFY, 3'h2, 24'h100010, 16'h0002, 1, 0);
        run_cmd(CMD_ERASE_VERIFY, 3'h2, 24'h100010, 16'h0002, 0, 1);
        run_cmd(CMD_PROGRAM, 3'h2, 24'h100010, 16'h0000, 1, 1);
        run_cmd(CMD_ERASE_SECTOR, 3'h1, 24'h100014, 16'h0000, 1, 0);
        run_cmd(CMD_ERASE_VERIFY, 3'h2, 24'h100014, 16'h0000, 1, 1);
        run_cmd(CMD_ERASE_VERIFY, 3'h3, 24'h100010, 16'h0001, 0, 0);
        run_cmd(CMD_PROGRAM, 3'h1, 24'h100010, 16'h0000, 0, 0);
        run_cmd(CMD_PROGRAM, 3'h6, 24'h100010, 16'h0000, 0, 0);
        run_cmd(CMD_ERASE_SECTOR, 3'h2, 24'h100010, 16'h0000, 0, 0);
        run_cmd(CMD_ERASE_VERIFY, 3'h2, 24'h100011, 16'h0001, 0, 0);
        run_cmd(CMD_ERASE_SECTOR, 3'h1, 24'h0f0010, 16'h0000, 0, 0);
        run_cmd(CMD_ERASE_VERIFY, 3'h2, 24'h1007fc, 16'h0003, 0, 0);
        run_cmd(CMD_PROGRAM, 3'h3, 24'h1007fe, 16'h0000, 0, 0);
        mode_allowed = 1'b0;
        run_cmd(CMD_PROGRAM, 3'h2, 24'h100010, 16'h0000, 0, 0);
        mode_allowed = 1'b1;
        run_cmd(CMD_ERASE_SECTOR, 3'h1, 24'h1003fc, 16'h0000, 0, 0);
        protect_from = 10'h1ff;
        run_cmd(CMD_PROGRAM, 3'h2, 24'h1003fe, 16'h0000, 0, 0);
        run_cmd(CMD_ERASE_SECTOR, 3'h1, 24'h1003fe, 16'h0000, 0, 0);
        run_cmd(CMD_ERASE_VERIFY, 3'h2, 24'h1003fc, 16'h0002, 0, 0);
        print_verdict();
    end
endmodule
